//--- pfbo_pkg.sv
/*
  Package for the program flash block overlay: address windows, mapping
  codes and reset kinds shared by the mapping logic and its testbench.
  Assumes 16-bit program addresses and a two-bit mapping field.
*/
package pfbo_pkg;

  localparam int          ADDR_W          = 16;
  localparam logic [15:0] LOW_WIN_LAST    = 16'h1FFF;
  localparam logic [15:0] SMALL_P_LAST    = 16'h7FFF;
  localparam logic [15:0] HIGH_WIN_FIRST  = 16'hE000;
  localparam logic [15:0] SEC_OFFS_MASK   = 16'h1FFF;

  localparam logic [1:0]  MAP_OVERLAY     = 2'h0;
  localparam logic [1:0]  MAP_BOTH_SMALL  = 2'h1;
  localparam logic [1:0]  MAP_RESET_VALUE = 2'h0;

  localparam logic        VARIANT_LARGE   = 1'h1;
  localparam logic        VARIANT_SMALL   = 1'h0;

  // configuration bit levels as read from non-volatile storage
  localparam logic        CFG_PROGRAMMED  = 1'h0;
  localparam logic        CFG_ERASED      = 1'h1;

  typedef enum logic [1:0] {
    RST_NONE     = 2'b00,
    RST_POWER    = 2'b01,
    RST_WATCHDOG = 2'b10,
    RST_SOFTWARE = 2'b11
  } pfbo_reset_kind_t;

  typedef enum logic [1:0] {
    BLK_NONE      = 2'b00,
    BLK_PRIMARY   = 2'b01,
    BLK_SECONDARY = 2'b10
  } pfbo_block_t;

endpackage : pfbo_pkg

//--- pfbo_map.sv
/*
  Program flash block overlay mapping: holds the two-bit block map field,
  loads it after each reset kind from the start-up configuration bits and
  routes fetch and in-application programming addresses to a flash block.
  Assumes all inputs but rst_n_i synchronous to clk_i; the reset kind is presented by
  the reset controller as a one-cycle pulse after the reset sequence.
*/
`timescale 1ns/1ps

// Summary of operation
// [R1] With the map field at 00, fetches in 0000H-1FFFH are served from the secondary block.
// [R2] With the map field at 00, fetches above 1FFFH are served from the primary block; on the small variant the code gives no block above 7FFFH.
// [R3] In overlay mode the hidden low 8 KByte of the primary block stays reachable by in-app programming.
// [R4] On the large variant any map value but 00 hides the secondary block, programmable at 0000H-1FFFH.
// [R5] On the small variant values 10 and 11 hide the secondary block, programmable at E000H-FFFFH.
// [R6] On the small variant value 01 maps 0000H-7FFFH to primary and E000H-FFFFH to secondary.
// [R7] After a reset the map field is loaded from the start-up bits according to the reset kind.
// [R8] The start-up bits change only by a programming command, never by this block.
// [R9] Software may rewrite map field bit 0 at run time with immediate effect on fetch mapping.
// [R10] A software write to map bit 0 leaves the start-up bit unchanged.
// [R11] Software must not switch mapping while running from the lowest 8 KByte window.
// [R12] Small variant power-on or external reset loads the inverse of both start-up bits.
// [R13] Small variant watchdog or brown-out and software resets follow the partial reload table.
// [R14] Large variant: bit 0 reloads as inverse start-up bit, bit 1 is 0, kept or 1 by reset kind.
// [R15] A programmed start-up bit reads as 0 and an erased one as 1.
// [R16] A map bit shown as don't-care in the reset table keeps its previous value.
module pfbo_map
  import pfbo_pkg::*;
#(
  parameter logic LARGE_PRIMARY = VARIANT_LARGE
) (
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic [1:0]          reset_kind_i,
  input  wire logic                startup_map_bit_low_i,
  input  wire logic                startup_map_bit_high_i,
  input  wire logic                map_bit0_wr_i,
  input  wire logic                map_bit0_data_i,
  input  wire logic [ADDR_W-1:0]   program_counter_i,
  input  wire logic                fetch_req_i,
  input  wire logic [ADDR_W-1:0]   in_app_programming_addr_i,
  input  wire logic                in_app_programming_req_i,
  output logic [1:0]               block_map_field_o,
  output logic [1:0]               fetch_block_o,
  output logic [ADDR_W-1:0]        fetch_offset_o,
  output logic [1:0]               prog_block_o,
  output logic [ADDR_W-1:0]        prog_offset_o
);

  logic                rst_sync1;
  logic                rst_sync2;
  logic [1:0]          block_map_field;
  logic [1:0]          next_map;
  logic [1:0]          fetch_blk;
  logic [1:0]          prog_blk;
  logic [ADDR_W-1:0]   fetch_offs;
  logic [ADDR_W-1:0]   prog_offs;

  // address lies in the lowest 8 KByte window
  function automatic logic in_low_window(input logic [ADDR_W-1:0] addr);
    return addr <= LOW_WIN_LAST;
  endfunction : in_low_window

  // address lies in the top 8 KByte window
  function automatic logic in_high_window(input logic [ADDR_W-1:0] addr);
    return addr >= HIGH_WIN_FIRST;
  endfunction : in_high_window

  // address lies beyond the end of a 32 KByte primary block
  function automatic logic past_small_primary(input logic [ADDR_W-1:0] addr);
    return addr > SMALL_P_LAST;
  endfunction : past_small_primary

  // offset within the secondary block for an address in the top window
  function automatic logic [ADDR_W-1:0] secondary_offset(input logic [ADDR_W-1:0] addr);
    return addr & SEC_OFFS_MASK;
  endfunction : secondary_offset

  // reload value of the map field for one reset kind
  function automatic logic [1:0] reload_value(input logic [1:0] kind,
                                              input logic [1:0] cur,
                                              input logic       hi,
                                              input logic       lo);
    logic [1:0] val;
    val = cur;
    case (kind)
      RST_POWER: begin
        if (LARGE_PRIMARY) begin
          val = {1'b0, ~lo}; // R14 R15
        end else begin
          val = {~hi, ~lo}; // R12 R15
        end
      end
      RST_WATCHDOG: begin
        if (LARGE_PRIMARY || hi == CFG_ERASED) begin
          val = {cur[1], ~lo}; // R13 R14 R16
        end else begin
          val = {1'b1, ~lo}; // R13
        end
      end
      RST_SOFTWARE: begin
        val = {1'b1, ~lo}; // R13 R14
      end
      default: begin
        val = cur;
      end
    endcase
    return val;
  endfunction : reload_value

  // fetch routing: block code in the top two bits, offset below
  function automatic logic [ADDR_W+1:0] fetch_route(input logic [1:0]        map,
                                                    input logic [ADDR_W-1:0] pc);
    pfbo_block_t       blk;
    logic [ADDR_W-1:0] offs;
    blk  = BLK_PRIMARY;
    offs = pc;
    if (map == MAP_OVERLAY) begin
      if (in_low_window(pc)) begin
        blk = BLK_SECONDARY; // R1
      end else if (!LARGE_PRIMARY && past_small_primary(pc)) begin
        // nothing behind these addresses on the small variant
        blk = BLK_NONE;
      end else begin
        blk = BLK_PRIMARY; // R2
      end
    end else if (!LARGE_PRIMARY && map == MAP_BOTH_SMALL) begin
      if (in_high_window(pc)) begin
        blk  = BLK_SECONDARY; // R6
        offs = secondary_offset(pc);
      end else if (past_small_primary(pc)) begin
        blk = BLK_NONE;
      end else begin
        blk = BLK_PRIMARY; // R6
      end
    end else if (!LARGE_PRIMARY && past_small_primary(pc)) begin
      blk = BLK_NONE; // R5
    end else begin
      blk = BLK_PRIMARY; // R4
    end
    return {blk, offs};
  endfunction : fetch_route

  // programming routing: overlay exposes the primary low window, else the secondary has a fixed window
  function automatic logic [ADDR_W+1:0] prog_route(input logic [1:0]        map,
                                                   input logic [ADDR_W-1:0] addr);
    pfbo_block_t       blk;
    logic [ADDR_W-1:0] offs;
    blk  = BLK_PRIMARY;
    offs = addr;
    if (map == MAP_OVERLAY) begin
      if (!LARGE_PRIMARY && past_small_primary(addr)) begin
        blk = BLK_NONE;
      end else begin
        blk = BLK_PRIMARY; // R3
      end
    end else if (LARGE_PRIMARY) begin
      if (in_low_window(addr)) begin
        blk = BLK_SECONDARY; // R4
      end else begin
        blk = BLK_PRIMARY;
      end
    end else begin
      if (in_high_window(addr)) begin
        blk  = BLK_SECONDARY; // R5
        offs = secondary_offset(addr);
      end else if (past_small_primary(addr)) begin
        blk = BLK_NONE;
      end else begin
        blk = BLK_PRIMARY;
      end
    end
    return {blk, offs};
  endfunction : prog_route

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync1 <= 1'b0;
      rst_sync2 <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_sync2 <= rst_sync1;
    end
  end

  // a reset kind pulse wins over a software write in the same cycle
  always_comb begin
    next_map = block_map_field;
    if (reset_kind_i != RST_NONE) begin
      next_map = reload_value(reset_kind_i, block_map_field,
                              startup_map_bit_high_i, startup_map_bit_low_i); // R7
    end else if (map_bit0_wr_i) begin
      // only the live field changes; start-up bits are inputs only
      next_map = {block_map_field[1], map_bit0_data_i}; // R9 R10 R8
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync2) begin
    if (!rst_sync2) begin
      block_map_field <= MAP_RESET_VALUE;
    end else begin
      block_map_field <= next_map; // R7
    end
  end

  // fetch routing uses the next field value so a bit 0 write acts at once
  always_comb begin
    {fetch_blk, fetch_offs} = fetch_route(next_map, program_counter_i); // R1 R2 R4 R5 R6
  end

  // programming routing follows the same next field value
  always_comb begin
    {prog_blk, prog_offs} = prog_route(next_map, in_app_programming_addr_i); // R3 R4 R5
  end

  always_ff @(posedge clk_i or negedge rst_sync2) begin
    if (!rst_sync2) begin
      block_map_field_o <= MAP_RESET_VALUE;
    end else begin
      block_map_field_o <= next_map;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync2) begin
    if (!rst_sync2) begin
      fetch_block_o  <= BLK_NONE;
      fetch_offset_o <= 16'h0000;
    end else begin
      fetch_block_o  <= fetch_req_i ? fetch_blk : BLK_NONE;
      fetch_offset_o <= fetch_offs;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync2) begin
    if (!rst_sync2) begin
      prog_block_o  <= BLK_NONE;
      prog_offset_o <= 16'h0000;
    end else begin
      prog_block_o  <= in_app_programming_req_i ? prog_blk : BLK_NONE;
      prog_offset_o <= prog_offs;
    end
  end

endmodule : pfbo_map

//--- pfbo_map_assertions.sv
/* pfbo_map port checker, small-variant relations; assumes the bind at the foot of this file */
`timescale 1ns/1ps
module pfbo_map_chk
  import pfbo_pkg::*;
#(parameter logic LARGE_PRIMARY = VARIANT_LARGE) (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [1:0]  reset_kind_i,
  input wire logic        startup_map_bit_low_i,
  input wire logic        startup_map_bit_high_i,
  input wire logic        map_bit0_wr_i,
  input wire logic        map_bit0_data_i,
  input wire logic [15:0] program_counter_i,
  input wire logic        fetch_req_i,
  input wire logic [15:0] in_app_programming_addr_i,
  input wire logic        in_app_programming_req_i,
  input wire logic [1:0]  block_map_field_o,
  input wire logic [1:0]  fetch_block_o,
  input wire logic [15:0] fetch_offset_o,
  input wire logic [1:0]  prog_block_o
);
  logic [1:0]  up;
  logic [15:0] pq;
  logic [15:0] aq;
  logic [1:0]  kq;
  logic [5:0]  bq;
  // live once the synchronised reset has let go
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  always_ff @(posedge clk_i) pq <= program_counter_i;
  always_ff @(posedge clk_i) aq <= in_app_programming_addr_i;
  always_ff @(posedge clk_i) kq <= reset_kind_i;
  always_ff @(posedge clk_i) bq <= {fetch_req_i, in_app_programming_req_i, map_bit0_wr_i, map_bit0_data_i,
                                    startup_map_bit_high_i, startup_map_bit_low_i};
  wire logic       sm = !LARGE_PRIMARY && up == 2'h3;
  wire logic [1:0] m  = block_map_field_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_overlay_low_sec:
    assert property (sm && bq[5] && m == 2'h0 && pq < 16'h2000 |-> fetch_block_o == BLK_SECONDARY) else $error("low fetch");
  a_overlay_high_pri:
    assert property (sm && bq[5] && m == 2'h0 && pq[15:13] inside {[3'h1:3'h3]} |-> fetch_block_o == BLK_PRIMARY)
      else $error("high fetch");
  a_both_high_sec:
    assert property (sm && bq[5] && m == 2'h1 && pq[15:13] == 3'h7
      |-> fetch_block_o == BLK_SECONDARY && fetch_offset_o == {3'h0, pq[12:0]}) else $error("high window");
  a_hidden_no_sec:
    assert property (sm && m[1] |-> fetch_block_o != BLK_SECONDARY) else $error("hidden fetch");
  a_prog_low_pri:
    assert property (sm && bq[4] && aq < 16'h2000 |-> prog_block_o == BLK_PRIMARY) else $error("low prog");
  a_power_load:
    assert property (sm && kq == RST_POWER |-> m == ~bq[1:0]) else $error("power load");
  a_soft_load:
    assert property (sm && kq == RST_SOFTWARE |-> m == {1'h1, !bq[0]}) else $error("soft load");
  a_bit0_write:
    assert property (sm && bq[3] && kq == RST_NONE |-> m == {$past(m[1]), bq[2]}) else $error("bit0 write");
endmodule : pfbo_map_chk

bind pfbo_map pfbo_map_chk #(.LARGE_PRIMARY(LARGE_PRIMARY)) chk_u (.*);

//--- pfbo_core_model.sv
/* core-side model: random fetch, programming and map bit 0 traffic; assumes the bench seeds $urandom */
`timescale 1ns/1ps
module pfbo_core_model
  import pfbo_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   en_i,
  output logic [15:0] pc_o,
  output logic [15:0] iap_addr_o,
  output logic [3:0]  req_o
);
  // half the addresses land on an 8 KByte window edge
  function automatic logic [15:0] pick();
    logic [15:0] a = 16'($urandom);
    return $urandom_range(1) ? {a[15:13], {13{a[0]}}} : a;
  endfunction : pick
  initial {pc_o, iap_addr_o, req_o} = '0;
  always @(posedge clk_i) begin : drive
    logic [15:0] a;
    a = pick();
    pc_o       <= a;
    iap_addr_o <= pick();
    req_o      <= {1'($urandom), en_i && a > LOW_WIN_LAST && $urandom_range(3) == 0, {2{en_i}} & 2'($urandom)};
  end
endmodule : pfbo_core_model

//--- tb_top.sv
/* bench for pfbo_map, small and large primary; core_u makes the traffic, route, route_l and load predict the outputs */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; $display("Error %0t %h %h", $time, a, b); end end
module tb_top;
  import pfbo_pkg::*;
  logic        clk_i = 1'h0, rst_n_i = 1'h0, en = 1'h0, chk = 1'h0;
  logic        startup_map_bit_low_i = 1'h1, startup_map_bit_high_i = 1'h1;
  logic [1:0]  reset_kind_i = 2'h0, block_map_field_o, fetch_block_o, prog_block_o, em = 2'h0, xfb, xpb;
  logic [15:0] program_counter_i, in_app_programming_addr_i, fetch_offset_o, prog_offset_o, xfo, xpo;
  logic [1:0]  lm_o, lfb_o, lpb_o, elm = 2'h0, xlfb, xlpb;
  logic [3:0]  req;
  wire logic   fetch_req_i = req[0], in_app_programming_req_i = req[1], map_bit0_wr_i = req[2], map_bit0_data_i = req[3];
  wire logic   hi = startup_map_bit_high_i, lo = startup_map_bit_low_i;
  int          fail_count = 0, samples_checked = 0;
  pfbo_core_model core_u (.clk_i(clk_i), .en_i(en), .pc_o(program_counter_i), .iap_addr_o(in_app_programming_addr_i),
    .req_o(req));
  pfbo_map #(.LARGE_PRIMARY(VARIANT_SMALL)) dut_u (.*);
  pfbo_map #(.LARGE_PRIMARY(VARIANT_LARGE)) dut_l_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .reset_kind_i(reset_kind_i),
    .startup_map_bit_low_i(lo), .startup_map_bit_high_i(hi), .map_bit0_wr_i(map_bit0_wr_i),
    .map_bit0_data_i(map_bit0_data_i), .program_counter_i(program_counter_i), .fetch_req_i(fetch_req_i),
    .in_app_programming_addr_i(in_app_programming_addr_i), .in_app_programming_req_i(in_app_programming_req_i),
    .block_map_field_o(lm_o), .fetch_block_o(lfb_o), .fetch_offset_o(), .prog_block_o(lpb_o), .prog_offset_o());
  function automatic logic [1:0] route_l(logic [1:0] m, logic [15:0] a, logic p);
    return (a <= LOW_WIN_LAST && ((m == MAP_OVERLAY) != p)) ? BLK_SECONDARY : BLK_PRIMARY;
  endfunction : route_l
  function automatic logic [17:0] route(logic [1:0] m, logic [15:0] a, logic p);
    if ((p ? m != MAP_OVERLAY : m == MAP_BOTH_SMALL) && a >= HIGH_WIN_FIRST) return {BLK_SECONDARY, a & SEC_OFFS_MASK};
    if (!p && m == MAP_OVERLAY && a <= LOW_WIN_LAST) return {BLK_SECONDARY, a};
    return a <= SMALL_P_LAST ? {BLK_PRIMARY, a} : {BLK_NONE, a};
  endfunction : route
  function automatic logic [1:0] load(logic [1:0] m, logic l);
    case (reset_kind_i)
      RST_POWER: return l ? {1'h0, ~lo} : ~{hi, lo};
      RST_WATCHDOG: return {(hi || l) ? m[1] : 1'h1, ~lo};
      RST_SOFTWARE: return {1'h1, ~lo};
      default: return map_bit0_wr_i ? {m[1], map_bit0_data_i} : m;
    endcase
  endfunction : load
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    em         <= load(em, 1'h0);
    {xfb, xfo} <= fetch_req_i ? route(load(em, 1'h0), program_counter_i, 1'h0) : 18'h0;
    {xpb, xpo} <= in_app_programming_req_i ? route(load(em, 1'h0), in_app_programming_addr_i, 1'h1) : 18'h0;
    elm        <= load(elm, 1'h1);
    xlfb       <= fetch_req_i ? route_l(load(elm, 1'h1), program_counter_i, 1'h0) : 2'h0;
    xlpb       <= in_app_programming_req_i ? route_l(load(elm, 1'h1), in_app_programming_addr_i, 1'h1) : 2'h0;
  end
  always @(negedge clk_i) begin
    if (chk) begin
      `CHK(block_map_field_o, em)
      `CHK(fetch_block_o, xfb)
      `CHK(prog_block_o, xpb)
      if (xfb != BLK_NONE) `CHK(fetch_offset_o, xfo)
      if (xpb != BLK_NONE) `CHK(prog_offset_o, xpo)
      `CHK(lm_o, elm)
      `CHK(lfb_o, xlfb)
      `CHK(lpb_o, xlpb)
    end
  end
  task automatic complete_run();
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial begin
    #20us;
    fail_count++;
    complete_run();
  end
  initial begin
    void'($urandom(15307));
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    {chk, en} <= 2'h3;
    for (int t = 0; t < 12; t++) begin
      {startup_map_bit_high_i, startup_map_bit_low_i} <= 2'(t);
      reset_kind_i <= 2'(t / 4 + 1);
      @(posedge clk_i);
      reset_kind_i <= RST_NONE;
      repeat (60) @(posedge clk_i);
      $display("test %0d done", t);
    end
    complete_run();
  end
endmodule : tb_top
